/* inc/crf_defines.vh */
// constants for the core register file: map, fields, reset values
`ifndef CRF_DEFINES_VH
`define CRF_DEFINES_VH

// register index map on the access port
`define CRF_IDX_W        5
`define CRF_IDX_SP       5'h0D
`define CRF_IDX_LINK     5'h0E
`define CRF_IDX_PC       5'h0F
`define CRF_IDX_COMBINED_PROGRAM_STATUS     5'h10
`define CRF_IDX_APPLICATION_STATUS_VIEW     5'h11
`define CRF_IDX_INTERRUPT_STATUS_VIEW     5'h12
`define CRF_IDX_EXECUTION_STATUS_VIEW     5'h13
`define CRF_IDX_GMASK    5'h14
`define CRF_IDX_FMASK    5'h15
`define CRF_IDX_THRESH   5'h16
`define CRF_IDX_CTRL     5'h17
`define CRF_LOW_LAST     5'h07
`define CRF_HIGH_LAST    5'h0C

// status word field positions
`define CRF_APPLICATION_STATUS_VIEW_LSB     27
`define CRF_APPLICATION_STATUS_VIEW_MSB     31
`define CRF_INTERRUPT_STATUS_VIEW_LSB     0
`define CRF_INTERRUPT_STATUS_VIEW_MSB     8
`define CRF_ICI_LSB      10
`define CRF_ICI_MSB      15
`define CRF_ITX_LSB      25
`define CRF_ITX_MSB      26
`define CRF_TBIT         24

// mode control bits
`define CRF_CTRL_USER    0
`define CRF_CTRL_STK     1

// alignment masks
`define CRF_SP_MASK      32'hFFFFFFFC
`define CRF_PC_MASK      32'hFFFFFFFE

// reset values
`define CRF_RST_WORD     32'h00000000
`define CRF_RST_CTRL     2'h0
`define CRF_RST_THRESH   9'h000

// interrupt classes
`define CRF_CLS_NORMAL   2'h0
`define CRF_CLS_NMI      2'h1
`define CRF_CLS_HARD     2'h2

// fault causes
`define CRF_FLT_NONE     2'h0
`define CRF_FLT_PRIV     2'h1
`define CRF_FLT_TBIT     2'h2

`endif

/* src/crf_core.v */
// architectural register file of the pipelined processor core
// Function
// - registers zero to twelve and the link register hold full 32-bit values
// - registers zero to seven reachable from every encoding
// - registers eight to twelve reachable from 32-bit encodings only
// - register thirteen banked; process copy only at user level thread
// - every other level and mode uses the main stack copy
// - stack pointer low two bits forced to zero
// - subroutine call writes return address into link register
// - program counter bit zero forced to zero
// - status word has three views, alone or together
// - application view holds condition flags in bits 27 to 31
// - interrupt view holds active exception number, bits 0 to 8
// - execution view holds state bits 10 to 15 and 25 to 26
// - bit 24 reads one in the execution and combined views; clearing it in a write to either raises a fault
// - general mask admits only nonmaskable interrupt and hard fault
// - fault mask admits only the nonmaskable interrupt
// - threshold blocks priorities equal to or above its value
// - threshold zero disables priority masking
// - control bit 0 selects thread privilege, one is user
// - control bit 1 selects process stack in user level thread mode
// - stack-select bit is zero while in handler mode
// - user level special register access, except the application view, blocked with a fault
// - handler mode while servicing an exception, always privileged
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "crf_defines.vh"

module crf_core #(
  parameter DATA_W = 32,
  parameter PRIO_W = 9,
  parameter NGPR   = 13
) (
  input  wire              sys_clk,
  input  wire              nrst,
  input  wire              ce,
  input  wire [4:0]        bus_addr,
  input  wire [DATA_W-1:0] bus_wdata,
  input  wire              bus_wr,
  input  wire              bus_rd,
  input  wire              bus_short,
  output reg  [DATA_W-1:0] bus_rdata,
  input  wire              call_en,
  input  wire [DATA_W-1:0] call_ret_addr,
  input  wire              pc_load,
  input  wire [DATA_W-1:0] pc_target,
  input  wire              flags_we,
  input  wire [4:0]        flags_in,
  input  wire              exc_enter,
  input  wire [8:0]        exc_number,
  input  wire              exc_return,
  input  wire              irq_valid,
  input  wire [1:0]        irq_class,
  input  wire [PRIO_W-1:0] irq_prio,
  output wire              irq_accept,
  output wire [DATA_W-1:0] pc_out,
  output wire [DATA_W-1:0] sp_out,
  output wire              handler_mode,
  output wire              user_level,
  output wire              psp_active,
  output reg               fault,
  output reg  [1:0]        fault_cause
);

  reg  [DATA_W-1:0] gpr_r [0:NGPR-1];
  reg  [DATA_W-1:0] main_stack_copy_r;
  reg  [DATA_W-1:0] process_stack_copy_r;
  reg  [DATA_W-1:0] link_register_r;
  reg  [DATA_W-1:0] program_counter_r;
  reg  [4:0]        app_flags_r;
  reg  [8:0]        exc_num_r;
  reg  [5:0]        ici_r;
  reg  [1:0]        itx_r;
  reg               gen_mask_r;
  reg               fault_mask_r;
  reg  [PRIO_W-1:0] thresh_r;
  reg  [1:0]        ctrl_r;
  reg               saved_stk_r;
  reg  [DATA_W-1:0] rdata_nxt;
  reg               fault_nxt;
  reg  [1:0]        cause_nxt;
  reg               wr_ok;
  wire              rd_ok;
  wire              thread_mode;
  wire              refused;
  wire              priv_block;
  wire              wr_gpr;
  wire              wr_sp;
  wire              wr_link;
  wire              wr_pc;
  wire              wr_app;
  wire              wr_exe;
  wire              wr_gmask;
  wire              wr_fmask;
  wire              wr_thresh;
  wire              wr_ctrl;
  wire [DATA_W-1:0] combined_program_status_word;
  wire [DATA_W-1:0] application_status_view_word;
  wire [DATA_W-1:0] interrupt_status_view_word;
  wire [DATA_W-1:0] execution_status_view_word;
  wire [DATA_W-1:0] sp_active;
  integer           i;

  // alignment forcing applied to every stored pointer value
  function [DATA_W-1:0] align;
    input [DATA_W-1:0] value;
    input [DATA_W-1:0] mask;
    begin
      align = value & mask;
    end
  endfunction

  // true when an index sits in the general register range
  function is_gpr;
    input [4:0] idx;
    begin
      is_gpr = (idx <= `CRF_HIGH_LAST);
    end
  endfunction

  // mode derivation
  assign handler_mode = (exc_num_r != 9'h000);
  assign thread_mode  = ~handler_mode;
  assign user_level   = thread_mode & ctrl_r[`CRF_CTRL_USER];
  assign psp_active   = user_level & ctrl_r[`CRF_CTRL_STK];
  assign sp_active    = psp_active ? process_stack_copy_r
                                   : main_stack_copy_r;
  assign sp_out       = sp_active;
  assign pc_out       = program_counter_r;

  // status views
  assign application_status_view_word = {app_flags_r, 27'h0000000};
  assign interrupt_status_view_word = {23'h000000, exc_num_r};
  assign execution_status_view_word = {5'h00, itx_r, 1'b1, 8'h00, ici_r,
                      10'h000};
  assign combined_program_status_word = application_status_view_word | interrupt_status_view_word | execution_status_view_word;

  // high group refused from short encodings
  assign refused = bus_short && (bus_addr > `CRF_LOW_LAST)
                   && is_gpr(bus_addr);
  // user level may reach only the application view among specials
  assign priv_block = user_level && (bus_addr >= `CRF_IDX_COMBINED_PROGRAM_STATUS)
                      && (bus_addr <= `CRF_IDX_CTRL)
                      && (bus_addr != `CRF_IDX_APPLICATION_STATUS_VIEW);
  assign rd_ok = bus_rd & ~refused & ~priv_block;

  // read mux, one cycle latency
  always @* begin
    rdata_nxt = `CRF_RST_WORD;
    if (rd_ok) begin
      if (is_gpr(bus_addr)) begin
        rdata_nxt = gpr_r[bus_addr[3:0]];
      end else begin
        case (bus_addr)
          `CRF_IDX_SP:     rdata_nxt = sp_active;
          `CRF_IDX_LINK:   rdata_nxt = link_register_r;
          `CRF_IDX_PC:     rdata_nxt = program_counter_r;
          `CRF_IDX_COMBINED_PROGRAM_STATUS:   rdata_nxt = combined_program_status_word;
          `CRF_IDX_APPLICATION_STATUS_VIEW:   rdata_nxt = application_status_view_word;
          `CRF_IDX_INTERRUPT_STATUS_VIEW:   rdata_nxt = interrupt_status_view_word;
          `CRF_IDX_EXECUTION_STATUS_VIEW:   rdata_nxt = execution_status_view_word;
          `CRF_IDX_GMASK:  rdata_nxt = {31'h00000000, gen_mask_r};
          `CRF_IDX_FMASK:  rdata_nxt = {31'h00000000, fault_mask_r};
          `CRF_IDX_THRESH: rdata_nxt = {{(DATA_W-PRIO_W){1'b0}},
                                        thresh_r};
          `CRF_IDX_CTRL:   rdata_nxt = {30'h00000000, ctrl_r};
          default:         rdata_nxt = `CRF_RST_WORD;
        endcase
      end
    end
  end

  // write acceptance and fault raising
  always @* begin
    wr_ok     = 1'b0;
    fault_nxt = 1'b0;
    cause_nxt = `CRF_FLT_NONE;
    if ((bus_wr || bus_rd) && priv_block) begin
      fault_nxt = 1'b1;
      cause_nxt = `CRF_FLT_PRIV;
    end else if (bus_wr && !refused) begin
      if (((bus_addr == `CRF_IDX_COMBINED_PROGRAM_STATUS) || (bus_addr == `CRF_IDX_EXECUTION_STATUS_VIEW))
          && !bus_wdata[`CRF_TBIT]) begin
        fault_nxt = 1'b1;
        cause_nxt = `CRF_FLT_TBIT;
      end else begin
        wr_ok = 1'b1;
      end
    end
  end

  // per-register write enables from an accepted port write
  assign wr_gpr    = wr_ok && is_gpr(bus_addr);
  assign wr_sp     = wr_ok && (bus_addr == `CRF_IDX_SP);
  assign wr_link   = wr_ok && (bus_addr == `CRF_IDX_LINK);
  assign wr_pc     = wr_ok && (bus_addr == `CRF_IDX_PC);
  assign wr_app    = wr_ok && ((bus_addr == `CRF_IDX_COMBINED_PROGRAM_STATUS)
                     || (bus_addr == `CRF_IDX_APPLICATION_STATUS_VIEW));
  assign wr_exe    = wr_ok && ((bus_addr == `CRF_IDX_COMBINED_PROGRAM_STATUS)
                     || (bus_addr == `CRF_IDX_EXECUTION_STATUS_VIEW));
  assign wr_gmask  = wr_ok && (bus_addr == `CRF_IDX_GMASK);
  assign wr_fmask  = wr_ok && (bus_addr == `CRF_IDX_FMASK);
  assign wr_thresh = wr_ok && (bus_addr == `CRF_IDX_THRESH);
  assign wr_ctrl   = wr_ok && (bus_addr == `CRF_IDX_CTRL);

  // read data stands for one cycle, then returns to zero
  always @(posedge sys_clk) begin
    if (!nrst) begin
      bus_rdata <= `CRF_RST_WORD;
    end else if (ce) begin
      bus_rdata <= rdata_nxt;
    end
  end

  // fault pulse with its cause
  always @(posedge sys_clk) begin
    if (!nrst) begin
      fault       <= 1'b0;
      fault_cause <= `CRF_FLT_NONE;
    end else if (ce) begin
      fault       <= fault_nxt;
      fault_cause <= cause_nxt;
    end
  end

  // general registers
  always @(posedge sys_clk) begin
    if (!nrst) begin
      for (i = 0; i < NGPR; i = i + 1) begin
        gpr_r[i] <= `CRF_RST_WORD;
      end
    end else if (ce && wr_gpr) begin
      gpr_r[bus_addr[3:0]] <= bus_wdata;
    end
  end

  // banked stack copies, low two bits dropped on write
  always @(posedge sys_clk) begin
    if (!nrst) begin
      main_stack_copy_r    <= `CRF_RST_WORD;
      process_stack_copy_r <= `CRF_RST_WORD;
    end else if (ce && wr_sp) begin
      if (psp_active) begin
        process_stack_copy_r <= align(bus_wdata, `CRF_SP_MASK);
      end else begin
        main_stack_copy_r <= align(bus_wdata, `CRF_SP_MASK);
      end
    end
  end

  // link register and program counter; core events win over the port
  always @(posedge sys_clk) begin
    if (!nrst) begin
      link_register_r   <= `CRF_RST_WORD;
      program_counter_r <= `CRF_RST_WORD;
    end else if (ce) begin
      if (wr_link) begin
        link_register_r <= bus_wdata;
      end
      if (call_en) begin
        link_register_r <= call_ret_addr;
      end
      if (wr_pc) begin
        program_counter_r <= align(bus_wdata, `CRF_PC_MASK);
      end
      if (pc_load) begin
        program_counter_r <= align(pc_target, `CRF_PC_MASK);
      end
    end
  end

  // status fields; flag updates from execution win over the port
  always @(posedge sys_clk) begin
    if (!nrst) begin
      app_flags_r <= 5'h00;
      ici_r       <= 6'h00;
      itx_r       <= 2'h0;
    end else if (ce) begin
      if (wr_app) begin
        app_flags_r <= bus_wdata[`CRF_APPLICATION_STATUS_VIEW_MSB:`CRF_APPLICATION_STATUS_VIEW_LSB];
      end
      if (wr_exe) begin
        ici_r <= bus_wdata[`CRF_ICI_MSB:`CRF_ICI_LSB];
        itx_r <= bus_wdata[`CRF_ITX_MSB:`CRF_ITX_LSB];
      end
      if (flags_we) begin
        app_flags_r <= flags_in;
      end
    end
  end

  // interrupt masking registers
  always @(posedge sys_clk) begin
    if (!nrst) begin
      gen_mask_r   <= 1'b0;
      fault_mask_r <= 1'b0;
      thresh_r     <= `CRF_RST_THRESH;
    end else if (ce) begin
      if (wr_gmask) begin
        gen_mask_r <= bus_wdata[0];
      end
      if (wr_fmask) begin
        fault_mask_r <= bus_wdata[0];
      end
      if (wr_thresh) begin
        thresh_r <= bus_wdata[PRIO_W-1:0];
      end
    end
  end

  // exception state and mode control; entry wins over return
  always @(posedge sys_clk) begin
    if (!nrst) begin
      exc_num_r   <= 9'h000;
      ctrl_r      <= `CRF_RST_CTRL;
      saved_stk_r <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_r[`CRF_CTRL_USER] <= bus_wdata[`CRF_CTRL_USER];
        ctrl_r[`CRF_CTRL_STK]  <= bus_wdata[`CRF_CTRL_STK]
                                  & thread_mode;
      end
      if (exc_enter) begin
        exc_num_r             <= exc_number;
        saved_stk_r           <= ctrl_r[`CRF_CTRL_STK];
        ctrl_r[`CRF_CTRL_STK] <= 1'b0;
      end else if (exc_return) begin
        exc_num_r             <= 9'h000;
        ctrl_r[`CRF_CTRL_STK] <= saved_stk_r;
      end
    end
  end

  crf_mask #(
    .PRIO_W     (PRIO_W)
  ) u_mask (
    .gen_mask   (gen_mask_r),
    .fault_mask (fault_mask_r),
    .thresh     (thresh_r),
    .irq_valid  (irq_valid),
    .irq_class  (irq_class),
    .irq_prio   (irq_prio),
    .irq_accept (irq_accept)
  );

endmodule
`default_nettype wire

/* src/crf_mask.v */
// interrupt acceptance under the three masking registers
`timescale 1ns/1ps
`default_nettype none
`include "crf_defines.vh"

module crf_mask #(
  parameter PRIO_W = 9
) (
  input  wire              gen_mask,
  input  wire              fault_mask,
  input  wire [PRIO_W-1:0] thresh,
  input  wire              irq_valid,
  input  wire [1:0]        irq_class,
  input  wire [PRIO_W-1:0] irq_prio,
  output reg               irq_accept
);

  wire thr_block;

  // zero threshold disables priority masking
  assign thr_block = (thresh != {PRIO_W{1'b0}}) && (irq_prio >= thresh);

  always @* begin
    irq_accept = 1'b0;
    if (irq_valid) begin
      case (irq_class)
        `CRF_CLS_NMI:  irq_accept = 1'b1;
        `CRF_CLS_HARD: irq_accept = ~fault_mask;
        default:       irq_accept = ~fault_mask & ~gen_mask & ~thr_block;
      endcase
    end
  end

endmodule
`default_nettype wire

/* testbench/cpu_core_register_file_bench.sv */
// self-checking bench for the core register file
`timescale 1ns/1ps
`default_nettype none
`include "crf_defines.vh"
module cpu_core_register_file_bench;
  logic        sys_clk, nrst, ce, bus_wr, bus_rd, bus_short, irq_valid;
  logic        call_en, pc_load, flags_we, exc_enter, exc_return, irq_accept;
  logic        handler_mode, user_level, psp_active, fault, g, f;
  logic [4:0]  bus_addr, flags_in, fl;
  logic [31:0] bus_wdata, bus_rdata, call_ret_addr, pc_target, pc_out;
  logic [31:0] sp_out, v, a, b, q;
  logic [31:0] gv [13];
  logic [8:0]  exc_number, irq_prio, t, pr;
  logic [1:0]  irq_class, fault_cause, cls;
  int          err_total, total_checks, cyc, i;
  crf_core DUT (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_short(bus_short), .bus_rdata(bus_rdata), .call_en(call_en),
    .call_ret_addr(call_ret_addr), .pc_load(pc_load), .pc_target(pc_target),
    .flags_we(flags_we), .flags_in(flags_in), .exc_enter(exc_enter),
    .exc_number(exc_number), .exc_return(exc_return), .irq_valid(irq_valid),
    .irq_class(irq_class), .irq_prio(irq_prio), .irq_accept(irq_accept),
    .pc_out(pc_out), .sp_out(sp_out), .handler_mode(handler_mode),
    .user_level(user_level), .psp_active(psp_active), .fault(fault),
    .fault_cause(fault_cause));
  crf_pipe_model pm (.sys_clk(sys_clk), .call_en(call_en),
    .call_ret_addr(call_ret_addr), .pc_load(pc_load), .pc_target(pc_target),
    .flags_we(flags_we), .flags_in(flags_in), .exc_enter(exc_enter),
    .exc_number(exc_number), .exc_return(exc_return));
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic exp_acc(logic gm, logic fm, logic [8:0] th,
                                   logic [1:0] c, logic [8:0] p);
    if (c == `CRF_CLS_NMI) return 1'h1;
    if (c == `CRF_CLS_HARD) return !fm;
    return !gm && !fm && !(th != 9'h000 && p >= th);
  endfunction
  task complete_run;
    if (err_total == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] ad, input logic [31:0] d);
    bus_addr <= ad;
    bus_wdata <= d;
    bus_wr <= 1'h1;
    @(posedge sys_clk);
    bus_wr <= 1'h0;
    bus_wdata <= ~d;
    #1;
  endtask
  task rdc(input logic [4:0] ad, input logic [31:0] exp);
    bus_addr <= ad;
    bus_rd <= 1'h1;
    @(posedge sys_clk);
    bus_rd <= 1'h0;
    #1 q = bus_rdata;
    chk(q, exp);
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      complete_run;
    end
  end
  initial begin
    {nrst, bus_wr, bus_rd, bus_short, irq_valid} = 5'h00;
    {bus_addr, bus_wdata, irq_class, irq_prio} = '0;
    {ce, err_total, total_checks, cyc} = {1'h1, 96'h0};
    void'($urandom(32'h7339));
    repeat (8) @(posedge sys_clk);
    nrst <= 1'h1;
    @(posedge sys_clk);
    #1;
    rdc(`CRF_IDX_COMBINED_PROGRAM_STATUS, 32'h01000000);
    rdc(`CRF_IDX_CTRL, 32'h0);
    rdc(5'h1F, 32'h0);
    for (i = 0; i < 13; i++) begin
      gv[i] = $urandom;
      wr(5'(i), gv[i]);
      rdc(5'(i), gv[i]);
    end
    ce <= 1'h0;
    wr(5'h00, ~gv[0]);
    pm.fire(0, gv[1]);
    ce <= 1'h1;
    rdc(5'h00, gv[0]);
    rdc(`CRF_IDX_LINK, 32'h0);
    bus_short <= 1'h1;
    wr(5'h09, ~gv[9]);
    for (i = 0; i < 13; i++) rdc(5'(i), i < 8 ? gv[i] : 32'h0);
    bus_short <= 1'h0;
    rdc(5'h09, gv[9]);
    v = $urandom;
    wr(`CRF_IDX_SP, v);
    chk(sp_out, v & `CRF_SP_MASK);
    wr(`CRF_IDX_PC, v);
    rdc(`CRF_IDX_PC, v & `CRF_PC_MASK);
    pm.fire(1, ~v);
    chk(pc_out, ~v & `CRF_PC_MASK);
    pm.fire(0, v);
    rdc(`CRF_IDX_LINK, v);
    fl = 5'($urandom);
    pm.fire(2, {27'h0, fl});
    rdc(`CRF_IDX_APPLICATION_STATUS_VIEW, {fl, 27'h0});
    v = ($urandom & 32'h0600FC00) | 32'h01000000;
    wr(`CRF_IDX_EXECUTION_STATUS_VIEW, v);
    rdc(`CRF_IDX_EXECUTION_STATUS_VIEW, v);
    rdc(`CRF_IDX_COMBINED_PROGRAM_STATUS, {fl, 27'h0} | v);
    wr(`CRF_IDX_EXECUTION_STATUS_VIEW, 32'h0);
    chk({fault, fault_cause}, {1'h1, `CRF_FLT_TBIT});
    rdc(`CRF_IDX_EXECUTION_STATUS_VIEW, v);
    v = ($urandom & 32'hFE00FC00) | 32'h01000000;
    wr(`CRF_IDX_COMBINED_PROGRAM_STATUS, v);
    rdc(`CRF_IDX_COMBINED_PROGRAM_STATUS, v);
    wr(`CRF_IDX_COMBINED_PROGRAM_STATUS, v & 32'hFEFFFFFF);
    chk({fault, fault_cause}, {1'h1, `CRF_FLT_TBIT});
    rdc(`CRF_IDX_COMBINED_PROGRAM_STATUS, v);
    wr(`CRF_IDX_APPLICATION_STATUS_VIEW, ~v);
    rdc(`CRF_IDX_APPLICATION_STATUS_VIEW, ~v & 32'hF8000000);
    pm.fire(3, 32'h5);
    chk(handler_mode, 32'h1);
    wr(`CRF_IDX_INTERRUPT_STATUS_VIEW, 32'h1FF);
    rdc(`CRF_IDX_INTERRUPT_STATUS_VIEW, 32'h5);
    pm.fire(4, 32'h0);
    rdc(`CRF_IDX_INTERRUPT_STATUS_VIEW, 32'h0);
    a = $urandom;
    b = $urandom;
    wr(`CRF_IDX_SP, a);
    wr(`CRF_IDX_CTRL, 32'h3);
    chk({psp_active, user_level}, 32'h3);
    wr(`CRF_IDX_SP, b);
    chk(sp_out, b & `CRF_SP_MASK);
    rdc(`CRF_IDX_GMASK, 32'h0);
    chk({fault, fault_cause}, {1'h1, `CRF_FLT_PRIV});
    wr(`CRF_IDX_GMASK, 32'h1);
    chk({fault, fault_cause}, {1'h1, `CRF_FLT_PRIV});
    pm.fire(3, 32'hB);
    chk(sp_out, a & `CRF_SP_MASK);
    chk({user_level, psp_active}, 32'h0);
    rdc(`CRF_IDX_CTRL, 32'h1);
    rdc(`CRF_IDX_GMASK, 32'h0);
    wr(`CRF_IDX_CTRL, 32'h2);
    rdc(`CRF_IDX_CTRL, 32'h0);
    pm.fire(4, 32'h0);
    wr(`CRF_IDX_CTRL, 32'h0);
    pm.fire(3, 32'h1);
    pm.fire(4, 32'h0);
    chk(handler_mode, 32'h0);
    repeat (40) begin
      {g, f} = 2'($urandom);
      t = 9'($urandom % 4);
      cls = 2'($urandom % 3);
      pr = 9'($urandom % 5);
      wr(`CRF_IDX_GMASK, {31'h0, g});
      wr(`CRF_IDX_FMASK, {31'h0, f});
      wr(`CRF_IDX_THRESH, {23'h0, t});
      irq_valid <= 1'h1;
      irq_class <= cls;
      irq_prio <= pr;
      #2 chk(irq_accept, exp_acc(g, f, t, cls, pr));
      rdc(`CRF_IDX_THRESH, {23'h0, t});
      rdc(`CRF_IDX_GMASK, {31'h0, g});
      rdc(`CRF_IDX_FMASK, {31'h0, f});
    end
    complete_run;
  end
endmodule
`default_nettype wire

/* testbench/crf_core_sva.sv */
// port assertions for the core register file
`timescale 1ns/1ps
`default_nettype none
`include "crf_defines.vh"
module crf_core_sva #(
  parameter DATA_W = 32,
  parameter PRIO_W = 9
) (
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic              ce,
  input wire logic [4:0]        bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic              bus_wr,
  input wire logic              bus_rd,
  input wire logic              bus_short,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic              pc_load,
  input wire logic [DATA_W-1:0] pc_target,
  input wire logic              exc_enter,
  input wire logic              exc_return,
  input wire logic              irq_valid,
  input wire logic [1:0]        irq_class,
  input wire logic              irq_accept,
  input wire logic [DATA_W-1:0] pc_out,
  input wire logic [DATA_W-1:0] sp_out,
  input wire logic              handler_mode,
  input wire logic              user_level,
  input wire logic              psp_active,
  input wire logic              fault,
  input wire logic [1:0]        fault_cause
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_enter; ce && exc_enter; endsequence
  sequence s_leave; ce && exc_return && !exc_enter; endsequence
  sequence s_user_rd;
    ce && bus_rd && user_level && (bus_addr == `CRF_IDX_COMBINED_PROGRAM_STATUS ||
      (bus_addr >= `CRF_IDX_INTERRUPT_STATUS_VIEW && bus_addr <= `CRF_IDX_CTRL));
  endsequence
  a_read_idle: assert property (ce && !bus_rd |=> bus_rdata == '0)
    else $error("read data outside its slot");
  a_short_high: assert property (ce && bus_rd && bus_short &&
    bus_addr > `CRF_LOW_LAST && bus_addr <= `CRF_HIGH_LAST
    |=> bus_rdata == '0 && !fault) else $error("short access reached high");
  a_user_fault: assert property (s_user_rd |=> fault &&
    fault_cause == `CRF_FLT_PRIV) else $error("user access not faulted");
  a_bit24_fault: assert property (ce && bus_wr && !user_level &&
    !bus_wdata[`CRF_TBIT] && (bus_addr == `CRF_IDX_COMBINED_PROGRAM_STATUS ||
    bus_addr == `CRF_IDX_EXECUTION_STATUS_VIEW) |=> fault && fault_cause == `CRF_FLT_TBIT)
    else $error("bit 24 clear not faulted");
  a_fault_origin: assert property (fault |->
    $past(ce && (bus_wr || bus_rd)) && fault_cause != `CRF_FLT_NONE)
    else $error("fault without a strobe");
  a_pc_load: assert property (ce && pc_load |=>
    pc_out == ($past(pc_target) & `CRF_PC_MASK)) else $error("bad jump");
  a_align_word: assert property (sp_out[1:0] == 2'h0 && !pc_out[0])
    else $error("pointer misaligned");
  a_enter_priv: assert property (s_enter |=>
    handler_mode && !user_level && !psp_active) else $error("bad entry");
  a_leave_thread: assert property (s_enter ##1 s_leave |=> !handler_mode)
    else $error("return kept handler mode");
  a_process_sel: assert property (psp_active |->
    user_level && !handler_mode) else $error("process copy misused");
  a_nmi_pass: assert property (irq_valid &&
    irq_class == `CRF_CLS_NMI |-> irq_accept) else $error("nmi refused");
endmodule
bind crf_core crf_core_sva #(.DATA_W(DATA_W), .PRIO_W(PRIO_W)) u_sva (
  .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_short(bus_short), .bus_rdata(bus_rdata), .pc_load(pc_load),
  .pc_target(pc_target), .exc_enter(exc_enter), .exc_return(exc_return),
  .irq_valid(irq_valid), .irq_class(irq_class), .irq_accept(irq_accept),
  .pc_out(pc_out), .sp_out(sp_out), .handler_mode(handler_mode),
  .user_level(user_level), .psp_active(psp_active), .fault(fault),
  .fault_cause(fault_cause));
`default_nettype wire

/* testbench/crf_pipe_model.sv */
// execution pipeline model issuing core event pulses
`timescale 1ns/1ps
`default_nettype none
module crf_pipe_model (
  input  wire logic        sys_clk,
  output logic             call_en,
  output logic [31:0]      call_ret_addr,
  output logic             pc_load,
  output logic [31:0]      pc_target,
  output logic             flags_we,
  output logic [4:0]       flags_in,
  output logic             exc_enter,
  output logic [8:0]       exc_number,
  output logic             exc_return
);
  initial begin
    {call_en, pc_load, flags_we, exc_enter, exc_return} = 5'h00;
    {call_ret_addr, pc_target, flags_in, exc_number} = '0;
  end
  // kind 0 call, 1 jump, 2 flags, 3 entry, 4 return; one-cycle pulse
  task fire(input int kind, input logic [31:0] v);
    case (kind)
      0: begin call_ret_addr <= v; call_en <= 1'h1; end
      1: begin pc_target <= v; pc_load <= 1'h1; end
      2: begin flags_in <= v[4:0]; flags_we <= 1'h1; end
      3: begin exc_number <= v[8:0]; exc_enter <= 1'h1; end
      default: exc_return <= 1'h1;
    endcase
    @(posedge sys_clk);
    {call_en, pc_load, flags_we, exc_enter, exc_return} <= 5'h00;
    // stale data lines show garbage once released
    {call_ret_addr, pc_target} <= {~v, ~v};
    {flags_in, exc_number} <= {~v[4:0], ~v[8:0]};
    #1;
  endtask
endmodule
`default_nettype wire
